// File: dv/pd_framer_properties.sv
// Purpose: Port properties of the packet framer
// Assumes: BIT_DIV is at least 4
// Notes:   Bound into every framer instance
`timescale 1ns/10ps
`include "pd_framer_defs.vh"
module pd_framer_checker #(
  parameter int BIT_DIV = 8
) (
  input wire logic       clk,
  input wire logic       resetn,
  input wire logic [1:0] port_role,
  input wire logic       explicit_contract,
  input wire logic       debug_en,
  input wire logic       tx_start,
  input wire logic [2:0] tx_class,
  input wire logic       tx_ready,
  input wire logic       tx_reject_reg,
  input wire logic       tx_line_reg,
  input wire logic       tx_active_reg,
  input wire logic       rx_start_reg,
  input wire logic [2:0] rx_class_reg,
  input wire logic       rx_data_valid_reg,
  input wire logic       rx_end_reg,
  input wire logic       rx_crc_ok_reg,
  input wire logic       rx_sym_err_reg
);
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  wire tx_go = tx_start && !tx_active_reg;
  plug_sop_tx_a: assert property (
    tx_go && port_role[1] && tx_class == `CLS_SOP |=> tx_reject_reg && !tx_active_reg)
    else $error("plug SOP start not refused");
  ufp_dbl_tx_a: assert property (
    tx_go && port_role == `ROLE_UFP && tx_class == `CLS_SOP2 |=> tx_reject_reg)
    else $error("UFP double prime start not refused");
  ufp_prime_tx_a: assert property (
    tx_go && port_role == `ROLE_UFP && explicit_contract && tx_class == `CLS_SOP1
    |=> tx_reject_reg) else $error("UFP prime start not refused");
  dfp_sop_tx_a: assert property (
    tx_go && port_role == `ROLE_DFP && tx_class == `CLS_SOP
    |=> tx_active_reg && !tx_reject_reg) else $error("DFP SOP start not taken");
  line_hold_a: assert property (
    $changed(tx_line_reg) |=> $stable(tx_line_reg) [*3]) else $error("line bit too short");
  ready_busy_a: assert property (
    tx_ready |-> tx_active_reg) else $error("ready while idle");
  plug_one_rx_a: assert property (
    rx_start_reg && port_role == `ROLE_PLUG1 |-> rx_class_reg == `CLS_SOP1)
    else $error("prime plug took other class");
  plug_two_rx_a: assert property (
    rx_start_reg && port_role == `ROLE_PLUG2 |-> rx_class_reg == `CLS_SOP2)
    else $error("double prime plug took other class");
  ufp_class_rx_a: assert property (
    rx_start_reg && port_role == `ROLE_UFP |-> rx_class_reg != `CLS_SOP2
    && !(explicit_contract && rx_class_reg == `CLS_SOP1)) else $error("UFP took bad class");
  dfp_class_rx_a: assert property (
    rx_start_reg && port_role == `ROLE_DFP && !debug_en |-> rx_class_reg <= `CLS_SOP2)
    else $error("DFP took debug class");
  byte_gap_a: assert property (
    rx_data_valid_reg |=> !rx_data_valid_reg [*8]) else $error("bytes too close");
  sym_drop_a: assert property (
    rx_end_reg && rx_sym_err_reg |-> !rx_crc_ok_reg) else $error("bad symbol delivered");
  cover property (rx_end_reg && rx_crc_ok_reg);
  cover property (tx_reject_reg);
  cover property ($fell(tx_active_reg));
endmodule
bind pd_phy_packet_framer pd_framer_checker #(.BIT_DIV(BIT_DIV)) chk_u (.*);

// File: dv/pd_line_partner.sv
// Purpose: Far-end PHY model: captures sent bits, replays frames
// Assumes: Bit ticks every DIV clocks from reset release
// Notes:   Samples mid-bit so a tick skew of a few clocks is tolerated
`timescale 1ns/10ps
module pd_line_partner #(
  parameter int DIV = 8
) (
  input  wire logic clk,
  input  wire logic resetn,
  input  wire logic tx_line_reg,
  input  wire logic tx_active_reg,
  output logic      rx_bit,
  output logic      rx_bit_valid,
  output logic      rx_idle
);
  logic snd [0:511];
  logic cap [0:511];
  int   cap_n;
  int   cnt;
  logic run;
  initial
  begin
    rx_bit = 1'b0;
    rx_bit_valid = 1'b0;
    rx_idle = 1'b1;
  end
  always @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      cnt <= 0;
      run <= 1'b0;
      cap_n <= 0;
    end
    else
    begin
      cnt <= (cnt == DIV - 1) ? 0 : cnt + 1;
      if (!tx_active_reg)
        run <= 1'b0;
      else if (cnt == 0 && !run)
      begin
        run <= 1'b1;
        cap_n <= 0;
      end
      if (run && tx_active_reg && cnt == DIV / 2)
      begin
        cap[cap_n] <= tx_line_reg;
        cap_n <= cap_n + 1;
      end
    end
  end
  task automatic send(input int n);
    rx_idle <= 1'b0;
    for (int i = 0; i < n; i++)
    begin
      @(posedge clk);
      rx_bit <= snd[i];
      rx_bit_valid <= 1'b1;
      @(posedge clk);
      rx_bit_valid <= 1'b0;
      repeat (DIV - 2) @(posedge clk);
    end
    @(posedge clk);
    rx_idle <= 1'b1;
    rx_bit <= ~rx_bit;
  endtask
endmodule

// File: dv/pd_phy_packet_framer_bench.sv
// Purpose: Self-checking bench for the packet framer
// Assumes: Partner loops captured frames back into the receiver
// Notes:   BIT_DIV cut to 8 to keep frames short
`timescale 1ns/10ps
`include "pd_framer_defs.vh"
module pd_phy_packet_framer_bench;
  localparam int DIV = 8;
  localparam logic [4:0] S1 = 5'h18;
  localparam logic [4:0] S2 = 5'h11;
  localparam logic [4:0] S3 = 5'h06;
  localparam logic [4:0] R2 = 5'h19;
  localparam logic [4:0] EP = 5'h0D;
  localparam logic [19:0] OSX [5] = '{{S2, S1, S1, S1}, {S3, S3, S1, S1}, {S3, S1, S3, S1},
                                      {S3, R2, R2, S1}, {S2, S3, R2, S1}};
  localparam logic [4:0] SYM [16] = '{5'h1E, 5'h09, 5'h14, 5'h15, 5'h0A, 5'h0B, 5'h0E,
    5'h0F, 5'h12, 5'h13, 5'h16, 5'h17, 5'h1A, 5'h1B, 5'h1C, 5'h1D};
  logic       clk;
  logic       resetn;
  logic [1:0] port_role;
  logic       is_source, explicit_contract, sop1_en, sop2_en, debug_en;
  logic       tx_start, tx_valid, tx_last, tx_abort;
  logic [2:0] tx_class;
  logic [7:0] tx_data;
  wire        tx_ready, tx_reject_reg, tx_done_reg, tx_underrun_reg, tx_line_reg;
  wire        tx_active_reg, rx_bit, rx_bit_valid, rx_idle, rx_start_reg;
  wire        rx_data_valid_reg, rx_end_reg, rx_crc_ok_reg, rx_sym_err_reg;
  wire  [2:0] rx_class_reg;
  wire  [7:0] rx_data_reg;
  int         errors, cmp_count, ns, nb, ne, nu;
  logic [2:0] rcls;
  logic       rok, rse;
  logic [7:0] rb [0:15];
  logic       frm [0:5][0:511];
  int         frm_n [0:5];
  pd_phy_packet_framer #(.BIT_DIV(DIV)) dut_u (.*);
  pd_line_partner #(.DIV(DIV)) p_u (.*);
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  always @(negedge clk)
  begin
    if (rx_start_reg === 1'b1)
    begin
      ns++;
      rcls = rx_class_reg;
    end
    if (rx_data_valid_reg === 1'b1 && nb < 16)
    begin
      rb[nb] = rx_data_reg;
      nb++;
    end
    if (rx_end_reg === 1'b1)
    begin
      ne++;
      rok = rx_crc_ok_reg;
      rse = rx_sym_err_reg;
    end
    if (tx_underrun_reg === 1'b1)
      nu++;
  end
  function automatic logic [7:0] dat(int i);
    return 8'h1F + 8'(i) * 8'h26;
  endfunction
  task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
    cmp_count++;
    if (g !== e)
    begin
      errors++;
      $display("[ERR] %s expected %0h seen %0h", nm, e, g);
    end
  endtask
  task automatic cmpf(string nm, int at, int w, logic [19:0] v);
    logic [19:0] g;
    g = '0;
    for (int k = 0; k < w; k++)
      g[k] = p_u.cap[at + k];
    chk(nm, v, g);
  endtask
  task automatic cfg(logic [1:0] r, logic s, logic x, logic p2, logic d);
    @(posedge clk);
    port_role <= r;
    is_source <= s;
    explicit_contract <= x;
    sop1_en <= 1'b1;
    sop2_en <= p2;
    debug_en <= d;
  endtask
  task automatic start(logic [2:0] c);
    @(posedge clk);
    tx_start <= 1'b1;
    tx_class <= c;
    @(posedge clk);
    tx_start <= 1'b0;
  endtask
  task automatic run_tx(logic [2:0] c, int n, logic ab);
    int bad;
    int s;
    logic [7:0] d;
    start(c);
    @(negedge clk);
    chk("tx_active", 1, tx_active_reg);
    @(posedge clk);
    for (int i = 0; i < n; i++)
    begin
      tx_data <= dat(i);
      tx_last <= (i == n - 1) && !ab;
      tx_valid <= 1'b1;
      do @(negedge clk); while (tx_ready !== 1'b1);
      @(posedge clk);
    end
    tx_valid <= 1'b0;
    tx_abort <= ab;
    bad = 0;
    while (tx_done_reg !== 1'b1 && bad < 4000)
    begin
      @(negedge clk);
      bad++;
    end
    chk("tx_done", 1, tx_done_reg);
    @(posedge clk);
    tx_abort <= 1'b0;
    bad = 0;
    for (int i = 0; i < 64; i++)
      bad += (p_u.cap[i] !== i[0]);
    chk("preamble", 0, bad);
    cmpf("start_set", 64, 20, OSX[c]);
    if (!ab)
    begin
      for (int i = 0; i < n; i++)
      begin
        d = dat(i);
        cmpf("byte", 84 + 10 * i, 10, {SYM[d[7:4]], SYM[d[3:0]]});
      end
      chk("length", 89 + 10 * (n + 4), p_u.cap_n);
    end
    else
      chk("short", 89 + 10 * n, p_u.cap_n);
    cmpf("eop", p_u.cap_n - 5, 5, EP);
    s = ab ? 5 : c;
    for (int i = 0; i < 512; i++)
      frm[s][i] = p_u.cap[i];
    frm_n[s] = p_u.cap_n;
  endtask
  task automatic rx_run(int s, int f1, int f2, int cut);
    for (int i = 0; i < 512; i++)
      p_u.snd[i] = frm[s][i] ^ (i == f1 || i == f2);
    ns = 0;
    nb = 0;
    ne = 0;
    @(posedge clk);
    p_u.send(frm_n[s] - cut);
    repeat (4 * DIV) @(posedge clk);
  endtask
  task automatic row(logic [1:0] r, logic s, logic x, logic p2, int c, int acc);
    cfg(r, s, x, p2, 1'b0);
    rx_run(c, -1, -1, 0);
    chk("rx_filter", acc, ns);
    if (acc == 0)
    begin
      start(3'(c));
      @(negedge clk);
      chk("tx_reject", 1, tx_reject_reg);
    end
  endtask
  task automatic t_frames;
    cfg(`ROLE_DFP, 1'b1, 1'b1, 1'b1, 1'b1);
    for (int c = 0; c < 5; c++)
    begin
      run_tx(3'(c), 2, 1'b0);
      rx_run(c, -1, -1, 0);
      chk("rx_start", 1, ns);
      chk("rx_class", c, rcls);
      chk("rx_bytes", 6, nb);
      chk("rx_byte0", dat(0), rb[0]);
      chk("rx_byte1", dat(1), rb[1]);
      chk("rx_end", 1, ne);
      chk("rx_crc_ok", 1, rok);
    end
    $display("t_frames done");
  endtask
  task automatic t_filter;
    row(`ROLE_UFP, 1'b1, 1'b1, 1'b1, 1, 0);
    row(`ROLE_UFP, 1'b0, 1'b0, 1'b1, 1, 0);
    row(`ROLE_UFP, 1'b1, 1'b0, 1'b1, 2, 0);
    row(`ROLE_UFP, 1'b0, 1'b1, 1'b1, 0, 1);
    row(`ROLE_PLUG1, 1'b0, 1'b0, 1'b1, 0, 0);
    row(`ROLE_PLUG1, 1'b0, 1'b0, 1'b1, 1, 1);
    row(`ROLE_PLUG1, 1'b0, 1'b0, 1'b1, 2, 0);
    row(`ROLE_PLUG2, 1'b0, 1'b0, 1'b1, 2, 1);
    row(`ROLE_PLUG2, 1'b0, 1'b0, 1'b1, 1, 0);
    row(`ROLE_DFP, 1'b1, 1'b1, 1'b0, 2, 0);
    row(`ROLE_DFP, 1'b1, 1'b1, 1'b1, 1, 1);
    row(`ROLE_DFP, 1'b1, 1'b1, 1'b1, 3, 0);
    $display("t_filter done");
  endtask
  task automatic t_errors;
    cfg(`ROLE_DFP, 1'b1, 1'b1, 1'b1, 1'b1);
    rx_run(0, 70, -1, 0);
    chk("one_bad_kcode", 1, ns);
    chk("one_bad_crc", 1, rok);
    rx_run(0, 65, 75, 0);
    chk("two_bad_kcodes", 0, ns);
    rx_run(0, 84, -1, 0);
    chk("data_flip_end", 1, ne);
    chk("data_flip_crc", 0, rok);
    chk("data_flip_sym", 0, rse);
    rx_run(0, 86, -1, 0);
    chk("kcode_in_data", 0, rok);
    chk("kcode_sym_err", 1, rse);
    rx_run(0, -1, -1, 5);
    chk("cut_end", 1, ne);
    chk("cut_crc", 0, rok);
    $display("t_errors done");
  endtask
  task automatic t_abort;
    run_tx(3'h0, 1, 1'b1);
    rx_run(5, -1, -1, 0);
    chk("abort_end", 1, ne);
    chk("abort_crc", 0, rok);
    $display("t_abort done");
  endtask
  task automatic t_underrun;
    int w;
    w = 0;
    start(3'h0);
    while (tx_done_reg !== 1'b1 && w < 4000)
    begin
      @(negedge clk);
      w++;
    end
    chk("underrun", 1, nu);
    chk("underrun_len", 89, p_u.cap_n);
    cmpf("underrun_eop", 84, 5, EP);
    $display("t_underrun done");
  endtask
  task automatic report_and_stop;
    $display("compares %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  initial
  begin
    resetn = 1'b0;
    {port_role, is_source, explicit_contract, sop1_en, sop2_en, debug_en} = '0;
    {tx_start, tx_valid, tx_last, tx_abort, tx_class, tx_data} = '0;
    repeat (16) @(posedge clk);
    resetn <= 1'b1;
    t_frames;
    t_filter;
    t_errors;
    t_abort;
    t_underrun;
    report_and_stop;
  end
  initial
  begin
    repeat (90000) @(posedge clk);
    errors++;
    $display("[ERR] watchdog expected end seen hang");
    report_and_stop;
  end
endmodule

// File: pkg/pd_framer_defs.vh
// Purpose: Constants for the packet framer: line codes, ordered sets, classes, CRC, timing
// Assumes: Included by bare name from the framer source
// Notes:   Ordered sets are packed with the first K-code in the low five bits
`ifndef PD_FRAMER_DEFS_VH
`define PD_FRAMER_DEFS_VH

// K-codes, sent least significant bit first
`define K_SYNC1        5'h18
`define K_SYNC2        5'h11
`define K_SYNC3        5'h06
`define K_RST1         5'h07
`define K_RST2         5'h19
`define K_EOP          5'h0D

// Start ordered sets, first K-code in bits 4:0
`define OS_SOP         {`K_SYNC2, `K_SYNC1, `K_SYNC1, `K_SYNC1}
`define OS_SOP1        {`K_SYNC3, `K_SYNC3, `K_SYNC1, `K_SYNC1}
`define OS_SOP2        {`K_SYNC3, `K_SYNC1, `K_SYNC3, `K_SYNC1}
`define OS_SOP1_DBG    {`K_SYNC3, `K_RST2, `K_RST2, `K_SYNC1}
`define OS_SOP2_DBG    {`K_SYNC2, `K_SYNC3, `K_RST2, `K_SYNC1}

// Start-of-packet classes
`define CLS_SOP        3'h0
`define CLS_SOP1       3'h1
`define CLS_SOP2       3'h2
`define CLS_SOP1_DBG   3'h3
`define CLS_SOP2_DBG   3'h4
`define CLS_NONE       3'h7

// Port roles
`define ROLE_DFP       2'h0
`define ROLE_UFP       2'h1
`define ROLE_PLUG1     2'h2
`define ROLE_PLUG2     2'h3

// Framing sizes in line bits; CRC_BYTES is the index of the last CRC byte
`define PREAMBLE_BITS  7'h40
`define SET_BITS       7'h14
`define BYTE_BITS      7'h0A
`define SYM_BITS       7'h05
`define CRC_BYTES      2'h3

// CRC-32
`define CRC_POLY       32'h04C11DB7
`define CRC_INIT       32'hFFFFFFFF
`define CRC_RESIDUAL   32'hC704DD7B

// Timing: system clock and line bit rate in kHz
`define CLK_KHZ        250000
`define BIT_KHZ        300
`define BIT_DIV_CYCLES (`CLK_KHZ / `BIT_KHZ)

`endif

// File: src/pd_phy_packet_framer.v
// Purpose: Packet framer and deframer between protocol layer and line bit stream
// Assumes: Line bits are NRZ at the bit rate; BFSK or BMC modulation sits outside
// Notes:   Received bytes stream out as they decode; the end pulse tells keep or drop
// Function
// - Byte ten line bits, word twenty, dword forty
// - Send preamble, start set, bytes, CRC, EOP
// - Whole packet goes out over BFSK or BMC
// - Preamble 64 alternating bits, 0 first, unencoded
// - SOP is three Sync-1 then Sync-2
// - Ports handle SOP; no valid SOP ignored
// - Only DFP and UFP send or accept SOP
// - SOP' is two Sync-1 then two Sync-3
// - SOP' plug accepts only SOP' packets
// - DFP or source takes SOP and SOP'
// - UFP explicit, sink non-explicit reject SOP'
// - SOP'' is Sync-1, Sync-3, Sync-1, Sync-3
// - SOP'' plug accepts only SOP'' packets
// - DFP with SOP'' also has SOP'
// - UFP never sends or accepts SOP''
// - Two debug start sets are reserved
// - Payload bytes become 5-bit data symbols
// - CRC follows last payload byte directly
// - Exactly one EOP right after CRC
// - On EOP check residual, deliver or discard
// - Early EOP truncates; receiver ends packet
// - Fixed K-code values; unassigned symbols are errors
// - Start set accepted with three of four
// - Nibbles map to fixed symbols, inverse decode
`timescale 1ns/10ps
`include "pd_framer_defs.vh"

module pd_phy_packet_framer #(
  parameter BIT_DIV = `BIT_DIV_CYCLES
) (
  input  wire       clk,
  input  wire       resetn,
  input  wire [1:0] port_role,
  input  wire       is_source,
  input  wire       explicit_contract,
  input  wire       sop1_en,
  input  wire       sop2_en,
  input  wire       debug_en,
  input  wire       tx_start,
  input  wire [2:0] tx_class,
  input  wire [7:0] tx_data,
  input  wire       tx_valid,
  input  wire       tx_last,
  input  wire       tx_abort,
  output wire       tx_ready,
  output reg        tx_reject_reg,
  output reg        tx_done_reg,
  output reg        tx_underrun_reg,
  output reg        tx_line_reg,
  output reg        tx_active_reg,
  input  wire       rx_bit,
  input  wire       rx_bit_valid,
  input  wire       rx_idle,
  output reg        rx_start_reg,
  output reg  [2:0] rx_class_reg,
  output reg  [7:0] rx_data_reg,
  output reg        rx_data_valid_reg,
  output reg        rx_end_reg,
  output reg        rx_crc_ok_reg,
  output reg        rx_sym_err_reg
);

  localparam ST_IDLE = 3'h0;
  localparam ST_PRE  = 3'h1;
  localparam ST_SET  = 3'h2;
  localparam ST_DATA = 3'h3;
  localparam ST_CRC  = 3'h4;
  localparam ST_EOP  = 3'h5;

  // 4b5b data symbol for a nibble
  function [4:0] enc4;
    input [3:0] n;
    begin
      case (n)
        4'h0: enc4 = 5'h1E;
        4'h1: enc4 = 5'h09;
        4'h2: enc4 = 5'h14;
        4'h3: enc4 = 5'h15;
        4'h4: enc4 = 5'h0A;
        4'h5: enc4 = 5'h0B;
        4'h6: enc4 = 5'h0E;
        4'h7: enc4 = 5'h0F;
        4'h8: enc4 = 5'h12;
        4'h9: enc4 = 5'h13;
        4'hA: enc4 = 5'h16;
        4'hB: enc4 = 5'h17;
        4'hC: enc4 = 5'h1A;
        4'hD: enc4 = 5'h1B;
        4'hE: enc4 = 5'h1C;
        default: enc4 = 5'h1D;
      endcase
    end
  endfunction

  // Inverse map: bit 4 flags a symbol that is not data
  function [4:0] dec5;
    input [4:0] s;
    begin
      case (s)
        5'h1E: dec5 = 5'h00;
        5'h09: dec5 = 5'h01;
        5'h14: dec5 = 5'h02;
        5'h15: dec5 = 5'h03;
        5'h0A: dec5 = 5'h04;
        5'h0B: dec5 = 5'h05;
        5'h0E: dec5 = 5'h06;
        5'h0F: dec5 = 5'h07;
        5'h12: dec5 = 5'h08;
        5'h13: dec5 = 5'h09;
        5'h16: dec5 = 5'h0A;
        5'h17: dec5 = 5'h0B;
        5'h1A: dec5 = 5'h0C;
        5'h1B: dec5 = 5'h0D;
        5'h1C: dec5 = 5'h0E;
        5'h1D: dec5 = 5'h0F;
        default: dec5 = 5'h10;
      endcase
    end
  endfunction

  // CRC-32 over one byte, bit 0 first
  function [31:0] crc_byte;
    input [31:0] c;
    input [7:0]  d;
    integer      i;
    reg   [31:0] r;
    reg          fb;
    begin
      r = c;
      for (i = 0; i < 8; i = i + 1)
      begin
        fb = r[31] ^ d[i];
        r = {r[30:0], 1'b0};
        if (fb)
          r = r ^ `CRC_POLY;
      end
      crc_byte = r;
    end
  endfunction

  // Complemented remainder, bit-reversed into field order
  function [31:0] crc_field;
    input [31:0] c;
    integer      i;
    begin
      for (i = 0; i < 32; i = i + 1)
        crc_field[i] = ~c[31 - i];
    end
  endfunction

  // Count of K-codes in their correct place
  function [2:0] hits;
    input [19:0] w;
    input [19:0] p;
    begin
      hits = {2'h0, w[4:0] == p[4:0]} + {2'h0, w[9:5] == p[9:5]}
           + {2'h0, w[14:10] == p[14:10]} + {2'h0, w[19:15] == p[19:15]};
    end
  endfunction

  // Which classes this port may send and accept
  reg [4:0] allow;
  always @*
  begin
    allow = 5'h00;
    case (port_role)
      `ROLE_DFP, `ROLE_UFP:
      begin
        allow[0] = 1'b1;
        allow[1] = sop1_en & (port_role == `ROLE_DFP | is_source)
                 & ~(port_role == `ROLE_UFP & explicit_contract)
                 & ~(~is_source & ~explicit_contract);
        allow[2] = sop2_en & sop1_en & (port_role == `ROLE_DFP);
        allow[3] = debug_en;
        allow[4] = debug_en;
      end
      `ROLE_PLUG1: allow[1] = 1'b1;
      `ROLE_PLUG2: allow[2] = 1'b1;
      default:     allow = 5'h00;
    endcase
  end

  // Bit-rate enable
  reg [15:0] div_reg;
  wire       bit_tick = (div_reg == 16'h0000);

  always @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      div_reg <= 16'h0000;
    else if (bit_tick)
      div_reg <= BIT_DIV[15:0] - 16'h0001;
    else
      div_reg <= div_reg - 16'h0001;
  end

  // Transmit
  reg [2:0]  tst_reg;
  reg [19:0] sh_reg;
  reg [6:0]  rem_reg;
  reg [31:0] tcrc_reg;
  reg [31:0] fld_reg;
  reg [1:0]  cidx_reg;
  reg [19:0] set_pat;
  wire [4:0]  eop_sym = `K_EOP;

  always @*
  begin
    case (tx_class)
      `CLS_SOP:      set_pat = `OS_SOP;
      `CLS_SOP1:     set_pat = `OS_SOP1;
      `CLS_SOP2:     set_pat = `OS_SOP2;
      `CLS_SOP1_DBG: set_pat = `OS_SOP1_DBG;
      default:       set_pat = `OS_SOP2_DBG;
    endcase
  end

  // Bytes are requested only between symbols, so the line never gaps mid-byte
  assign tx_ready = (tst_reg == ST_DATA) && (rem_reg == 7'h00) && !tx_abort;

  always @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      tst_reg         <= ST_IDLE;
      sh_reg          <= 20'h00000;
      rem_reg         <= 7'h00;
      tcrc_reg        <= `CRC_INIT;
      fld_reg         <= 32'h00000000;
      cidx_reg        <= 2'h0;
      tx_reject_reg   <= 1'b0;
      tx_done_reg     <= 1'b0;
      tx_underrun_reg <= 1'b0;
      tx_line_reg     <= 1'b0;
      tx_active_reg   <= 1'b0;
    end
    else
    begin
      tx_reject_reg   <= 1'b0;
      tx_done_reg     <= 1'b0;
      tx_underrun_reg <= 1'b0;
      if (bit_tick && rem_reg != 7'h00)
      begin
        // Preamble alternates from the count; the rest shifts out LSB first
        tx_line_reg <= (tst_reg == ST_PRE) ? rem_reg[0] : sh_reg[0];
        sh_reg      <= {1'b0, sh_reg[19:1]};
        rem_reg     <= rem_reg - 7'h01;
      end
      else if (rem_reg == 7'h00)
      begin
        case (tst_reg)
          ST_IDLE:
          begin
            if (tx_active_reg)
            begin
              // Stay active through the last EOP bit period, else the modulator cuts it
              if (bit_tick)
              begin
                tx_active_reg <= 1'b0;
                tx_done_reg   <= 1'b1;
              end
            end
            else if (tx_start && tx_class <= `CLS_SOP2_DBG && allow[tx_class])
            begin
              tst_reg       <= ST_PRE;
              rem_reg       <= `PREAMBLE_BITS;
              tcrc_reg      <= `CRC_INIT;
              tx_active_reg <= 1'b1;
            end
            else if (tx_start)
              tx_reject_reg <= 1'b1;
          end
          ST_PRE:
          begin
            tst_reg <= ST_SET;
            sh_reg  <= set_pat;
            rem_reg <= `SET_BITS;
          end
          ST_SET, ST_DATA:
          begin
            if (tx_abort)
            begin
              tst_reg <= ST_IDLE;
              sh_reg  <= {15'h0000, `K_EOP};
              rem_reg <= `SYM_BITS;
            end
            else if (tst_reg == ST_SET || tx_valid)
            begin
              tst_reg <= ST_DATA;
              if (tst_reg == ST_DATA)
              begin
                sh_reg   <= {10'h000, enc4(tx_data[7:4]), enc4(tx_data[3:0])};
                rem_reg  <= `BYTE_BITS;
                tcrc_reg <= crc_byte(tcrc_reg, tx_data);
                if (tx_last)
                begin
                  tst_reg  <= ST_CRC;
                  fld_reg  <= crc_field(crc_byte(tcrc_reg, tx_data));
                  cidx_reg <= 2'h0;
                end
              end
            end
            else if (bit_tick)
            begin
              // Late byte: first EOP bit leaves on this tick, so the line never stalls
              tst_reg         <= ST_IDLE;
              tx_line_reg     <= eop_sym[0];
              sh_reg          <= {16'h0000, eop_sym[4:1]};
              rem_reg         <= `SYM_BITS - 7'h01;
              tx_underrun_reg <= 1'b1;
            end
          end
          ST_CRC:
          begin
            sh_reg   <= {10'h000, enc4(fld_reg[7:4]), enc4(fld_reg[3:0])};
            fld_reg  <= {8'h00, fld_reg[31:8]};
            rem_reg  <= `BYTE_BITS;
            cidx_reg <= cidx_reg + 2'h1;
            if (cidx_reg == `CRC_BYTES)
              tst_reg <= ST_EOP;
          end
          ST_EOP:
          begin
            sh_reg  <= {15'h0000, `K_EOP};
            rem_reg <= `SYM_BITS;
            tst_reg <= ST_IDLE;
          end
          default: tst_reg <= ST_IDLE;
        endcase
      end
    end
  end

  // Receive
  reg        rbody_reg;
  reg [19:0] win_reg;
  reg [2:0]  scnt_reg;
  reg        half_reg;
  reg [3:0]  lo_reg;
  reg [31:0] rcrc_reg;
  reg [2:0]  det_cls;
  wire [19:0] win_next = {rx_bit, win_reg[19:1]};
  wire [4:0]  sym      = win_next[19:15];
  wire [4:0]  dsym     = dec5(sym);
  wire [7:0]  rbyte    = {dsym[3:0], lo_reg};

  always @*
  begin
    // Three of four K-codes in place are enough
    if (hits(win_next, `OS_SOP) >= 3'h3)
      det_cls = `CLS_SOP;
    else if (hits(win_next, `OS_SOP1) >= 3'h3)
      det_cls = `CLS_SOP1;
    else if (hits(win_next, `OS_SOP2) >= 3'h3)
      det_cls = `CLS_SOP2;
    else if (hits(win_next, `OS_SOP1_DBG) >= 3'h3)
      det_cls = `CLS_SOP1_DBG;
    else if (hits(win_next, `OS_SOP2_DBG) >= 3'h3)
      det_cls = `CLS_SOP2_DBG;
    else
      det_cls = `CLS_NONE;
  end

  always @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      rbody_reg         <= 1'b0;
      win_reg           <= 20'h00000;
      scnt_reg          <= 3'h0;
      half_reg          <= 1'b0;
      lo_reg            <= 4'h0;
      rcrc_reg          <= `CRC_INIT;
      rx_start_reg      <= 1'b0;
      rx_class_reg      <= `CLS_NONE;
      rx_data_reg       <= 8'h00;
      rx_data_valid_reg <= 1'b0;
      rx_end_reg        <= 1'b0;
      rx_crc_ok_reg     <= 1'b0;
      rx_sym_err_reg    <= 1'b0;
    end
    else
    begin
      rx_start_reg      <= 1'b0;
      rx_data_valid_reg <= 1'b0;
      rx_end_reg        <= 1'b0;
      if (rbody_reg && rx_idle)
      begin
        // Line went quiet mid-packet: drop it
        rbody_reg      <= 1'b0;
        rx_end_reg     <= 1'b1;
        rx_crc_ok_reg  <= 1'b0;
        rx_sym_err_reg <= 1'b0;
        win_reg        <= 20'h00000;
      end
      else if (rx_bit_valid)
      begin
        win_reg <= win_next;
        if (!rbody_reg)
        begin
          // Unknown or filtered start sets leave the hunt running
          if (det_cls != `CLS_NONE && allow[det_cls])
          begin
            rbody_reg     <= 1'b1;
            rx_start_reg  <= 1'b1;
            rx_class_reg  <= det_cls;
            rx_crc_ok_reg <= 1'b0;
            rx_sym_err_reg <= 1'b0;
            scnt_reg      <= 3'h0;
            half_reg      <= 1'b0;
            rcrc_reg      <= `CRC_INIT;
          end
        end
        else if (scnt_reg != 3'h4)
          scnt_reg <= scnt_reg + 3'h1;
        else
        begin
          scnt_reg <= 3'h0;
          if (sym == `K_EOP)
          begin
            rbody_reg     <= 1'b0;
            rx_end_reg    <= 1'b1;
            rx_crc_ok_reg <= !half_reg && (rcrc_reg == `CRC_RESIDUAL);
            win_reg       <= 20'h00000;
          end
          else if (dsym[4])
          begin
            rbody_reg      <= 1'b0;
            rx_end_reg     <= 1'b1;
            rx_crc_ok_reg  <= 1'b0;
            rx_sym_err_reg <= 1'b1;
            win_reg        <= 20'h00000;
          end
          else if (!half_reg)
          begin
            lo_reg   <= dsym[3:0];
            half_reg <= 1'b1;
          end
          else
          begin
            half_reg          <= 1'b0;
            rx_data_reg       <= rbyte;
            rx_data_valid_reg <= 1'b1;
            rcrc_reg          <= crc_byte(rcrc_reg, rbyte);
          end
        end
      end
    end
  end

endmodule
